// *** include/cep_regs.svh ***
// constants and behaviour list for the command entry panel
// Behaviour
// [RL1] Each function-code module has four toggle switches, one per code bit, and the panel holds four modules.
// [RL2] The lower lamp of a function switch lights red when its entered bit is one.
// [RL3] Each press of a function switch flips its entered bit.
// [RL4] The computer drives the upper white lamp of each switch to show a verified transmitted one.
// [RL5] The execute lamp lights green while a function-code command is in process at the computer.
// [RL6] In lockout the lockout lamp is lit and no function code is executed or sent.
// [RL7] Lockout does not block entry of function-code bits.
// [RL8] A code entered in lockout is sent only after lockout is removed and execute is pressed again.
// [RL9] Holding lamp check forces all function-switch, execute and lockout lamps on; the code forces only the function-code lamps, not the parameter execute lamp.
// [RL10] The parameter module takes ten digit positions, each from a twelve-position rotary switch.
// [RL11] Each position encodes digits zero to nine, plus or minus, and its indicator shows the selection.
// [RL12] The parameter execute lamp lights only while the command is on the lines to the computer.
// [RL13] After a parameter command the computer sends a verify word that lights the verify lamps.
// [RL14] The computer issues a single command or a subroutine series depending on the code.
// [RL15] The function-code execute lamp is set by the press and cleared only by the computer's acknowledge; lockout also clears a queued, unsent press.
// [RL16] Every switch press is debounced so one press gives one toggle or one execute request.
`ifndef CEP_REGS_SVH
`define CEP_REGS_SVH
`define CEP_NUM_MODULES    4
`define CEP_CODE_BITS      4
`define CEP_NUM_DIGITS     10
`define CEP_ROTARY_POS     12
`define CEP_CHAR_BITS      4
`define CEP_VERIFY_BITS    4
`define CEP_DEBOUNCE_NS    5000000
`define CEP_CLK_NS         25
`define CEP_DEBOUNCE_CYC   ((`CEP_DEBOUNCE_NS + `CEP_CLK_NS - 1) / `CEP_CLK_NS)
`define CEP_CHAR_PLUS      4'hA
`define CEP_CHAR_MINUS     4'hB
`endif

// *** include/cep_pkg.sv ***
// types shared by the command entry panel
package cep_pkg;
   typedef struct packed {
      logic [3:0] code;       // function code carried to the computer
      logic [1:0] module_sel; // which function-code module sends
   } cep_fcmd_type;
   typedef struct packed {
      logic [39:0] digits;    // ten four-bit characters, digit 0 in low bits
   } cep_pcmd_type;
   typedef enum logic [1:0] {
      CEP_P_IDLE = 2'b00,
      CEP_P_SEND = 2'b01,
      CEP_P_WAIT = 2'b10
   } cep_pstate_type;
endpackage

// *** rtl/cep_panel.sv ***
// command entry panel: four function-code modules and one parameter module
`timescale 1ns/1ps
`include "cep_regs.svh"
module cep_panel #(
   parameter int NUM_MODULES  = `CEP_NUM_MODULES,
   parameter int DEBOUNCE_CYC = `CEP_DEBOUNCE_CYC
) (
   // clock and reset
   input  wire logic                   ref_clk,
   input  wire logic                   reset,
   // function-code module switches, four code bits per module, one execute and one lockout bit per module
   input  wire logic [NUM_MODULES*4-1:0] function_switch,
   input  wire logic [NUM_MODULES-1:0] execute_request,
   input  wire logic [NUM_MODULES-1:0] command_lockout,
   input  wire logic                   lamp_check,
   // function-code link to the computer
   output cep_pkg::cep_fcmd_type       fcmd,
   output logic                        fcmd_valid,
   input  wire logic                   fcmd_ack,
   input  wire logic [NUM_MODULES*4-1:0] verified_bits,
   // function-code lamps
   output logic [NUM_MODULES*4-1:0]    entry_lamp,
   output logic [NUM_MODULES*4-1:0]    verified_lamp,
   output logic [NUM_MODULES-1:0]      execute_lamp,
   output logic [NUM_MODULES-1:0]      lockout_lamp,
   // parameter module switches and link
   input  wire logic [10*4-1:0]        rotary_position,
   input  wire logic                   param_execute_request,
   input  wire logic                   param_lockout,
   output cep_pkg::cep_pcmd_type       pcmd,
   output logic                        pcmd_valid,
   input  wire logic                   pcmd_taken,
   input  wire logic                   verify_valid,
   input  wire logic [3:0]             verify_word,
   // parameter lamps
   output logic [10*4-1:0]             char_display,
   output logic                        param_execute_lamp,
   output logic [3:0]                  verify_lamp
);
   import cep_pkg::*;

   // one debounce lane per raw switch, counters sized to the window
   localparam int NSW = NUM_MODULES * 6 + 1;
   localparam int DBW = $clog2(DEBOUNCE_CYC + 1);

   // the link names the sender in two bits, so four modules at most
   generate
      if (NUM_MODULES < 1 || NUM_MODULES > `CEP_NUM_MODULES ||
          DEBOUNCE_CYC < 1) begin : g_bad_cfg
         $error("cep_panel: unsupported parameters");
      end
   endgenerate

   // ==========================================================
   // switch debounce
   // ==========================================================
   wire logic [NSW-1:0] raw_sw = {param_execute_request, command_lockout,
                                 execute_request, function_switch};
   logic [NSW-1:0] clean_sw;
   logic [NSW-1:0] clean_q;
   wire  logic [NSW-1:0] press = clean_sw & ~clean_q;  // rising edge, one per press

   // trade-off: a long window rejects bounce but delays every press
   genvar g;
   generate
      for (g = 0; g < NSW; g++) begin : g_db
         logic [DBW-1:0] cnt;
         // level must hold stable a full window before it is believed
         always_ff @(posedge ref_clk or posedge reset) begin
            if (reset) begin
               cnt         <= '0;
               clean_sw[g] <= 1'b0;
            end else if (raw_sw[g] == clean_sw[g]) begin
               cnt <= '0;
            end else if (cnt == DBW'(DEBOUNCE_CYC - 1)) begin
               cnt         <= '0;
               clean_sw[g] <= raw_sw[g];  // RL16
            end else begin
               cnt <= cnt + 1'b1;
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) clean_q <= '0;
      else       clean_q <= clean_sw;
   end

   // split the debounced edges back into their switch groups
   wire logic [NUM_MODULES*4-1:0] fsw_press = press[NUM_MODULES*4-1:0];
   wire logic [NUM_MODULES-1:0]   xeq_press = press[NUM_MODULES*5-1:NUM_MODULES*4];
   // lockout is a held level, not a pulse
   wire logic [NUM_MODULES-1:0]   locked    = clean_sw[NUM_MODULES*6-1:NUM_MODULES*5];
   wire logic                     pxeq_press = press[NSW-1];

   // ==========================================================
   // function-code modules
   // ==========================================================
   // entered bits, queued and in-flight requests per module
   logic [NUM_MODULES*4-1:0] entered;
   logic [NUM_MODULES-1:0]   pending;
   logic [NUM_MODULES-1:0]   busy;
   logic [1:0]               sender;

   // entry toggles regardless of lockout
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) entered <= '0;
      else       entered <= entered ^ fsw_press;  // RL3 RL7 RL1
   end

   // a press under lockout is dropped; a fresh press after release sends
   wire logic [NUM_MODULES-1:0] next_pending =
      (pending | (xeq_press & ~locked & ~busy)) & ~locked;  // RL6 RL8

   // lowest pending module wins the single link
   // limitation: fixed priority, a chatty low module can hold off the rest
   function automatic logic [1:0] first_one(input logic [NUM_MODULES-1:0] v);
      first_one = '0;
      for (int i = NUM_MODULES - 1; i >= 0; i--)
         if (v[i]) first_one = 2'(i);
   endfunction

   // a module locked in this very cycle may not launch its stale request
   wire logic [NUM_MODULES-1:0] sendable = pending & ~locked;  // RL6
   wire logic       link_free = !fcmd_valid && (busy == '0);
   wire logic [1:0] pick      = first_one(sendable);
   wire logic       launch    = link_free && (sendable != '0);  // RL8

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         pending    <= '0;
         busy       <= '0;
         sender     <= '0;
         fcmd_valid <= 1'b0;
         fcmd       <= '0;
      end else begin
         pending <= launch ? (next_pending & ~(NUM_MODULES'(1) << pick)) : next_pending;
         if (launch) begin
            sender     <= pick;
            busy[pick] <= 1'b1;                   // RL15
            fcmd_valid <= 1'b1;
            fcmd.code  <= entered[pick*`CEP_CODE_BITS +: `CEP_CODE_BITS];
            fcmd.module_sel <= pick;
         end else if (fcmd_valid && fcmd_ack) begin
            fcmd_valid   <= 1'b0;
            busy[sender] <= 1'b0;                 // RL15
         end
      end
   end

   // lamps, lamp check overrides all stored state
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         entry_lamp    <= '0;
         verified_lamp <= '0;
         execute_lamp  <= '0;
         lockout_lamp  <= '0;
      end else begin
         entry_lamp    <= entered | {NUM_MODULES*4{lamp_check}};        // RL2 RL9
         verified_lamp <= verified_bits | {NUM_MODULES*4{lamp_check}};  // RL4 RL9
         execute_lamp  <= (busy | pending) | {NUM_MODULES{lamp_check}}; // RL5 RL9
         lockout_lamp  <= locked | {NUM_MODULES{lamp_check}};           // RL6 RL9
      end
   end

   // ==========================================================
   // parameter module
   // ==========================================================
   // parameter link state
   cep_pstate_type pstate;
   // out-of-range rotary codes show as the minus character
   function automatic logic [3:0] char_of(input logic [3:0] p);
      char_of = (p < 4'(`CEP_ROTARY_POS)) ? p : `CEP_CHAR_MINUS;
   endfunction

   logic [39:0] chars;
   always_comb begin
      for (int d = 0; d < `CEP_NUM_DIGITS; d++)
         chars[d*4 +: 4] = char_of(rotary_position[d*4 +: 4]);  // RL10 RL11
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         pstate             <= CEP_P_IDLE;
         pcmd               <= '0;
         pcmd_valid         <= 1'b0;
         param_execute_lamp <= 1'b0;
         verify_lamp        <= '0;
         char_display       <= '0;
      end else begin
         char_display <= chars;  // RL11
         // one word in flight; an execute pressed before the verify answer is ignored
         case (pstate)
            CEP_P_IDLE: begin
               if (pxeq_press && !param_lockout) begin
                  pstate             <= CEP_P_SEND;
                  pcmd.digits        <= chars;
                  pcmd_valid         <= 1'b1;
                  param_execute_lamp <= 1'b1;  // RL12
                  verify_lamp        <= '0;
               end
            end
            CEP_P_SEND: begin
               if (pcmd_taken) begin
                  pstate             <= CEP_P_WAIT;
                  pcmd_valid         <= 1'b0;
                  param_execute_lamp <= 1'b0;  // RL12
               end
            end
            CEP_P_WAIT: begin
               if (verify_valid) begin
                  pstate      <= CEP_P_IDLE;
                  verify_lamp <= verify_word;  // RL13
               end
            end
            default: pstate <= CEP_P_IDLE;
         endcase
      end
   end
endmodule

// *** sim/cep_panel_checker.sv ***
// port assertions for the command entry panel
`timescale 1ns/1ps
module cep_panel_checker #(
   parameter int NUM_MODULES = 4
) (
   // clock, reset, lamp test
   input wire logic                   ref_clk,
   input wire logic                   reset,
   input wire logic                   lamp_check,
   // function-code link and lamps
   input cep_pkg::cep_fcmd_type       fcmd,
   input wire logic                   fcmd_valid,
   input wire logic                   fcmd_ack,
   input wire logic [NUM_MODULES*4-1:0] entry_lamp,
   input wire logic [NUM_MODULES-1:0] execute_lamp,
   input wire logic [NUM_MODULES-1:0] lockout_lamp,
   // parameter link and lamps
   input cep_pkg::cep_pcmd_type       pcmd,
   input wire logic                   pcmd_valid,
   input wire logic                   pcmd_taken,
   input wire logic                   param_execute_lamp,
   input wire logic                   verify_valid,
   input wire logic [3:0]             verify_word,
   input wire logic [3:0]             verify_lamp
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   // ==========
   // lamps are registered, so the test must be held two edges
   sequence s_held; lamp_check ##1 lamp_check; endsequence
   a_lamp_test_all: assert property (s_held |-> &{entry_lamp, execute_lamp, lockout_lamp})
      else $error("lamp dark in lamp test");
   a_locked_no_send: assert property ($rose(fcmd_valid) && !$past(lamp_check)
      |-> !lockout_lamp[fcmd.module_sel])
      else $error("command sent while locked");
   a_fcmd_holds: assert property (fcmd_valid && !fcmd_ack |=> fcmd_valid && $stable(fcmd))
      else $error("command dropped before ack");
   a_ack_ends: assert property (fcmd_valid && fcmd_ack |=> !fcmd_valid)
      else $error("command kept after ack");
   a_exec_lamp_busy: assert property (fcmd_valid |-> execute_lamp[fcmd.module_sel])
      else $error("execute lamp dark in process");
   a_param_lamp_lines: assert property (param_execute_lamp == pcmd_valid)
      else $error("param lamp off the lines");
   a_pcmd_holds: assert property (pcmd_valid && !pcmd_taken |=> pcmd_valid && $stable(pcmd))
      else $error("param word dropped early");
   a_verify_shows: assert property (verify_valid |-> ##[1:2] verify_lamp == verify_word)
      else $error("verify lamps wrong");
endmodule
bind cep_panel cep_panel_checker #(.NUM_MODULES(NUM_MODULES)) cep_panel_checker_i (.*);

// *** sim/cep_computer_model.sv ***
// behavioural command computer on the panel links
`timescale 1ns/1ps
module cep_computer_model (
   // clock, reset, answer delay
   input wire logic             ref_clk,
   input wire logic             reset,
   input int                    ack_delay,
   // function-code link
   input cep_pkg::cep_fcmd_type fcmd,
   input wire logic             fcmd_valid,
   output logic                 fcmd_ack,
   output logic [15:0]          verified_bits,
   // parameter link
   input wire logic             pcmd_valid,
   output logic                 pcmd_taken,
   output logic                 verify_valid,
   output logic [3:0]           verify_word
);
   int cnt;
   // ==========
   // answers after ack_delay cycles; zero makes it prompt, so the lamp flash is short
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         {fcmd_ack, pcmd_taken, verify_valid, verify_word, verified_bits} <= '0;
         cnt <= 0;
      end else begin
         cnt <= ((fcmd_valid && !fcmd_ack) || (pcmd_valid && !pcmd_taken)) ? cnt + 1 : 0;
         fcmd_ack <= fcmd_valid && !fcmd_ack && cnt >= ack_delay;
         pcmd_taken <= pcmd_valid && !pcmd_taken && cnt >= ack_delay;
         verify_valid <= pcmd_taken;
         if (fcmd_valid && !fcmd_ack && cnt >= ack_delay)
            verified_bits[fcmd.module_sel*4 +: 4] <= fcmd.code;
         if (pcmd_valid && !pcmd_taken)
            verify_word <= 4'h5; // weights 1 and 4
      end
   end
endmodule

// *** sim/testbench.sv ***
// self-checking bench for the command entry panel
`timescale 1ns/1ps
module testbench;
   import cep_pkg::*;
   // ==========
   // panel signals and counters
   logic        ref_clk = 1'b0, reset = 1'b1, lamp_check = 1'b0;
   logic        param_execute_request = 1'b0, param_lockout = 1'b0;
   logic [15:0] function_switch = '0;
   logic [3:0]  execute_request = '0, command_lockout = '0;
   logic [39:0] rotary_position = '0;
   int          ack_delay = 20, err_count = 0, n_tests = 0;
   cep_fcmd_type fcmd;
   cep_pcmd_type pcmd;
   logic        fcmd_valid, fcmd_ack, pcmd_valid, pcmd_taken, verify_valid, param_execute_lamp;
   logic [15:0] verified_bits, entry_lamp, verified_lamp;
   logic [3:0]  execute_lamp, lockout_lamp, verify_word, verify_lamp;
   logic [39:0] char_display;
   cep_panel #(.DEBOUNCE_CYC(4)) cep_panel_i (.*);
   cep_computer_model cep_computer_model_i (.*);
   // 25 ns clock
   initial forever #12.5 ref_clk = ~ref_clk;
   // ==========
   // helpers
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         err_count++;
      end
   endtask
   // held and released well past the debounce span
   task automatic press(input int k, input int i);
      @(negedge ref_clk);
      if (k == 0) function_switch[i] = 1'b1;
      else if (k == 1) execute_request[i] = 1'b1;
      else param_execute_request = 1'b1;
      repeat (8) @(negedge ref_clk);
      {function_switch, execute_request, param_execute_request} = '0;
      repeat (8) @(negedge ref_clk);
   endtask
   task automatic idle_wait();
      repeat (100) if (fcmd_valid !== 1'b0 || pcmd_valid !== 1'b0) @(negedge ref_clk);
      repeat (3) @(negedge ref_clk);
   endtask
   // ==========
   // scenarios
   task automatic t_entry();
      chk({fcmd_valid, entry_lamp}, 17'h0);
      press(0, 3);
      press(0, 2);
      chk(entry_lamp, 16'h000C);
      press(0, 3);
      chk(entry_lamp, 16'h0004);
      // a two-cycle bounce is shorter than the window and must not toggle
      @(negedge ref_clk);
      function_switch[0] = 1'b1;
      repeat (2) @(negedge ref_clk);
      function_switch[0] = 1'b0;
      repeat (8) @(negedge ref_clk);
      chk(entry_lamp, 16'h0004);
      $display("entry done");
   endtask
   task automatic t_execute();
      press(1, 0);
      chk({fcmd_valid, execute_lamp, fcmd}, {1'b1, 4'h1, 4'h4, 2'h0});
      idle_wait();
      chk({execute_lamp, verified_lamp}, {4'h0, 16'h0004});
      $display("execute done");
   endtask
   task automatic t_lockout();
      ack_delay = 0;
      command_lockout[1] = 1'b1;
      repeat (8) @(negedge ref_clk);
      chk(lockout_lamp, 4'h2);
      press(0, 4);
      press(1, 1);
      chk({fcmd_valid, entry_lamp}, {1'b0, 16'h0014});
      command_lockout[1] = 1'b0;
      repeat (8) @(negedge ref_clk);
      chk(verified_lamp, 16'h0004);
      press(1, 1);
      idle_wait();
      chk(verified_lamp, 16'h0014);
      ack_delay = 20;
      $display("lockout done");
   endtask
   task automatic t_lamp();
      lamp_check = 1'b1;
      repeat (3) @(negedge ref_clk);
      chk({entry_lamp, verified_lamp, execute_lamp, lockout_lamp}, 40'hFFFFFFFFFF);
      lamp_check = 1'b0;
      repeat (3) @(negedge ref_clk);
      chk(entry_lamp, 16'h0014);
      $display("lamp done");
   endtask
   task automatic t_param();
      rotary_position = 40'hFBA9876543;
      repeat (8) @(negedge ref_clk);
      chk(char_display, 40'hBBA9876543);
      param_lockout = 1'b1;
      press(2, 0);
      chk({pcmd_valid, param_execute_lamp}, 2'h0);
      param_lockout = 1'b0;
      rotary_position = 40'h0BA9876543;
      press(2, 0);
      chk(pcmd, 40'h0BA9876543);
      chk({pcmd_valid, param_execute_lamp}, 2'h3);
      idle_wait();
      chk({param_execute_lamp, verify_lamp}, 5'h05);
      $display("param done");
   endtask
   task automatic end_sim();
      $display("tests=%0d errors=%0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // main sequence after five reset cycles
   initial begin
      repeat (5) @(negedge ref_clk);
      reset = 1'b0;
      repeat (8) @(negedge ref_clk);
      t_entry();
      t_execute();
      t_lockout();
      t_lamp();
      t_param();
      end_sim();
   end
   // watchdog: the run needs well under 1000 cycles
   initial begin
      #(25 * 5000);
      err_count++;
      end_sim();
   end
endmodule
